/* adc_cfg_pkg.sv */
// Register map constants for the ADC configuration register bank.
package adc_cfg_pkg;
   // Register offsets.
   localparam logic [7:0] SOFT_RESET_ADDR = 8'h01;
   localparam logic [7:0] GENERAL_CFG_ADDR = 8'h02;
   localparam logic [7:0] FILTER_CFG_ADDR = 8'h03;
   localparam logic [7:0] ISO_ACCESS_ADDR = 8'h05;
   localparam logic [7:0] WAVE_BASE_ADDR = 8'h26;
   localparam logic [7:0] WAVE_LAST_ADDR = 8'h2E;
   localparam logic [7:0] SHORT_ADDR = 8'hCC;
   // Byte step between channel waveform groups.
   localparam logic [7:0] WAVE_STRIDE = 8'h03;
   // Values after reset.
   localparam logic [7:0] GENERAL_CFG_RESET = 8'h02;
   localparam logic [7:0] FILTER_CFG_RESET = 8'h00;
   localparam logic [7:0] ISO_ACCESS_RESET = 8'h00;
   localparam logic [7:0] SHORT_RESET = 8'h00;
   localparam logic [23:0] WAVE_RESET = 24'h000000;
   // Soft reset command byte.
   localparam logic [7:0] SOFT_RESET_CMD = 8'hD6;
   // Writable bit masks; other bits are reserved and read zero.
   localparam logic [7:0] GENERAL_CFG_MASK = 8'h0F;
   localparam logic [7:0] FILTER_CFG_MASK = 8'h7F;
   localparam logic [7:0] ISO_ACCESS_MASK = 8'h01;
   localparam logic [7:0] SHORT_MASK = 8'h01;
   // Field positions.
   localparam int MODE_LSB = 2;
   localparam int CRC_EN_BIT = 1;
   localparam int CLOCK_OUTPUT_ENABLE_BIT = 0;
   localparam int V2_INV_BIT = 6;
   localparam int V1_INV_BIT = 5;
   localparam int I_INV_BIT = 4;
   localparam int LOWPASS_BANDWIDTH_SELECT_BIT = 3;
   localparam int ISO_WR_BIT = 0;
   // Waveform debug modes.
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_STATIC = 2'h1;
   localparam logic [1:0] MODE_COUNT = 2'h2;
   localparam logic [1:0] MODE_RESERVED = 2'h3;
   // Output sample rate codes: 32, 8, 4 and 2 kHz.
   localparam logic [1:0] RATE_32K = 2'h0;
   localparam logic [1:0] RATE_8K = 2'h1;
   localparam logic [1:0] RATE_4K = 2'h2;
   localparam logic [1:0] RATE_2K = 2'h3;
   localparam int NUM_CHANNELS = 3;
endpackage : adc_cfg_pkg

/* wave_ctrl_if.sv */
// Shared control bundle from the register bank to the waveform channels.
`timescale 1ns/100ps
`default_nettype none
interface wave_ctrl_if;
   logic [1:0] modeSel;
   logic sampleReady;
   logic writeAllowed;
   logic softReset;
   logic wrEn;
   logic [7:0] wrAddr;
   logic [7:0] wrData;
   modport bank (output modeSel, sampleReady, writeAllowed, softReset, wrEn, wrAddr, wrData);
   modport channel (input modeSel, sampleReady, writeAllowed, softReset, wrEn, wrAddr, wrData);
endinterface : wave_ctrl_if
`default_nettype wire

/* waveform_channel.sv */
// One 24-bit channel waveform register with normal, static and count modes.
`timescale 1ns/100ps
`default_nettype none
module waveform_channel #(
   parameter logic [7:0] BASE_ADDR = 8'h26
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   wave_ctrl_if.channel ctrl,
   input wire logic [23:0] result,
   output logic [23:0] waveValue
);
   logic [23:0] valueReg;
   logic hitHi;
   logic hitMd;
   logic hitLo;
   logic wrHit;

   // Byte decode of this channel's three addresses, high byte first.
   assign hitHi = (ctrl.wrAddr == BASE_ADDR);
   assign hitMd = (ctrl.wrAddr == BASE_ADDR + 8'h01);
   assign hitLo = (ctrl.wrAddr == BASE_ADDR + 8'h02);
   assign wrHit = ctrl.wrEn && ctrl.writeAllowed && (hitHi || hitMd || hitLo);
   assign waveValue = valueReg;

   // A host write wins over a same-cycle sample update so debug values are never lost.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         valueReg <= adc_cfg_pkg::WAVE_RESET;
      else if (ctrl.softReset)
         valueReg <= adc_cfg_pkg::WAVE_RESET;
      else if (wrHit)
      begin
         if (hitHi)
            valueReg[23:16] <= ctrl.wrData;
         if (hitMd)
            valueReg[15:8] <= ctrl.wrData;
         if (hitLo)
            valueReg[7:0] <= ctrl.wrData;
      end
      else
      begin
         case (ctrl.modeSel)
            adc_cfg_pkg::MODE_STATIC: valueReg <= valueReg; // Hold. [RULE3]
            adc_cfg_pkg::MODE_COUNT:
               if (ctrl.sampleReady)
                  valueReg <= valueReg + 24'h000001; // [RULE5]
            default:
               if (ctrl.sampleReady)
                  valueReg <= result; // Normal and reserved alike. [RULE2] [RULE6]
         endcase
      end
   end

   property p_normal_load;
      @(posedge ref_clk) disable iff (!rst_b)
      (ctrl.modeSel == adc_cfg_pkg::MODE_NORMAL && ctrl.sampleReady && !wrHit && !ctrl.softReset)
      |=> (valueReg == $past(result));
   endproperty
   a_normal_load: assert property (p_normal_load) else $error("Normal sample missed."); // [RULE2]

   property p_static_hold;
      @(posedge ref_clk) disable iff (!rst_b)
      (ctrl.modeSel == adc_cfg_pkg::MODE_STATIC && !wrHit && !ctrl.softReset)
      |=> $stable(valueReg);
   endproperty
   a_static_hold: assert property (p_static_hold) else $error("Static value moved."); // [RULE3]

   property p_count_step;
      @(posedge ref_clk) disable iff (!rst_b)
      (ctrl.modeSel == adc_cfg_pkg::MODE_COUNT && ctrl.sampleReady && !wrHit && !ctrl.softReset)
      |=> (valueReg == $past(valueReg) + 24'h000001);
   endproperty
   a_count_step: assert property (p_count_step) else $error("Count did not step."); // [RULE5]

   property p_reserved_load;
      @(posedge ref_clk) disable iff (!rst_b)
      (ctrl.modeSel == adc_cfg_pkg::MODE_RESERVED && ctrl.sampleReady && !wrHit && !ctrl.softReset)
      |=> (valueReg == $past(result));
   endproperty
   a_reserved_load: assert property (p_reserved_load) else $error("Code 11 not live."); // [RULE6]
endmodule : waveform_channel
`default_nettype wire

/* adc_config_register_bank.sv */
// Configuration register bank of a multi-channel sigma-delta ADC.
// Operation
// (RULE1) Command 0xD6 restores all register defaults.
// (RULE2) Debug mode 00: waveforms track conversion results.
// (RULE3) Debug mode 01: waveforms hold until written.
// (RULE4) Host selects count mode before static.
// (RULE5) Debug mode 10: writable, increment per sample.
// (RULE6) Debug code 11 behaves as normal.
// (RULE7) Config bit 1 enables write CRC, default on.
// (RULE8) Config bit 0 picks clock or ready pin.
// (RULE9) Filter bits 6..4 invert V2, V1, I.
// (RULE10) Filter bit 3 selects lowpass bandwidth.
// (RULE11) Path 000 sinc3 only; 001 adds lowpass.
// (RULE12) Register 0xCC shorts current channel inputs.
// (RULE13) Short writable only with isolated write enable.
// (RULE14) Path codes 010-111 compensation and rates.
// (RULE15) Reset command reads zero; other values ignored.
// (RULE16) Reserved bits read zero, ignore writes.
`timescale 1ns/100ps
`default_nettype none
module adc_config_register_bank (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   output logic regRdValid,
   input wire logic sampleReadyPulse,
   input wire logic [23:0] currentResult,
   input wire logic [23:0] firstVoltageResult,
   input wire logic [23:0] secondVoltageResult,
   output logic [1:0] waveformDebugSelect,
   output logic crcCheckEnable,
   output logic clockOutputEnable,
   output logic clockOutputPin,
   output logic secondVoltageInvert,
   output logic firstVoltageInvert,
   output logic currentInvert,
   output logic lowpassBandwidthSelect,
   output logic [2:0] processingPathSelect,
   output logic lowpassEnable,
   output logic compensationEnable,
   output logic [1:0] sampleRateSelect,
   output logic isolatedWriteEnable,
   output logic currentInputShort
);
   logic [7:0] generalCfgReg, filterCfgReg, isoAccessReg, shortReg, rdataReg, rdataNext;
   logic writeUnlockReg, clkDivReg, pinReg, lowpassReg, compReg, rdValidReg, softResetHit;
   logic [1:0] rateReg, modeSel;
   logic [23:0] waveValue [adc_cfg_pkg::NUM_CHANNELS];
   logic [23:0] waveResult [adc_cfg_pkg::NUM_CHANNELS];
   wave_ctrl_if waveCtrl ();

   // Only the exact command byte resets; any other byte is dropped. [RULE1] [RULE15]
   assign softResetHit = regWrite && (regAddr == adc_cfg_pkg::SOFT_RESET_ADDR)
                         && (regWdata == adc_cfg_pkg::SOFT_RESET_CMD);
   assign modeSel = generalCfgReg[adc_cfg_pkg::MODE_LSB +: 2];

   // General config: debug mode, write CRC enable and clock output select.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         generalCfgReg <= adc_cfg_pkg::GENERAL_CFG_RESET; // CRC check on. [RULE7]
      else if (softResetHit)
         generalCfgReg <= adc_cfg_pkg::GENERAL_CFG_RESET; // [RULE1]
      else if (regWrite && regAddr == adc_cfg_pkg::GENERAL_CFG_ADDR)
         generalCfgReg <= regWdata & adc_cfg_pkg::GENERAL_CFG_MASK; // [RULE16]
   end

   // Filter config: inversions, bandwidth and processing path.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         filterCfgReg <= adc_cfg_pkg::FILTER_CFG_RESET;
      else if (softResetHit)
         filterCfgReg <= adc_cfg_pkg::FILTER_CFG_RESET; // [RULE1]
      else if (regWrite && regAddr == adc_cfg_pkg::FILTER_CFG_ADDR)
         filterCfgReg <= regWdata & adc_cfg_pkg::FILTER_CFG_MASK; // [RULE16]
   end

   // Isolated write enable guards the input short register.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         isoAccessReg <= adc_cfg_pkg::ISO_ACCESS_RESET;
      else if (softResetHit)
         isoAccessReg <= adc_cfg_pkg::ISO_ACCESS_RESET; // [RULE1]
      else if (regWrite && regAddr == adc_cfg_pkg::ISO_ACCESS_ADDR)
         isoAccessReg <= regWdata & adc_cfg_pkg::ISO_ACCESS_MASK; // [RULE16]
   end

   // Writes without the enable are silently dropped to protect offset calibration.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         shortReg <= adc_cfg_pkg::SHORT_RESET;
      else if (softResetHit)
         shortReg <= adc_cfg_pkg::SHORT_RESET; // [RULE1]
      else if (regWrite && regAddr == adc_cfg_pkg::SHORT_ADDR
               && isoAccessReg[adc_cfg_pkg::ISO_WR_BIT]) // [RULE13]
         shortReg <= regWdata & adc_cfg_pkg::SHORT_MASK; // [RULE12] [RULE16]
   end

   // Count mode unlocks waveform writes; static mode keeps the unlock, so a host
   // going straight from normal to static gets a frozen but unwritable value.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         writeUnlockReg <= 1'b0;
      else if (softResetHit)
         writeUnlockReg <= 1'b0;
      else if (modeSel == adc_cfg_pkg::MODE_COUNT)
         writeUnlockReg <= 1'b1; // [RULE4] [RULE5]
      else if (modeSel != adc_cfg_pkg::MODE_STATIC)
         writeUnlockReg <= 1'b0;
   end

   // Control bundle for the waveform channels.
   assign waveCtrl.modeSel = modeSel;
   assign waveCtrl.sampleReady = sampleReadyPulse;
   assign waveCtrl.writeAllowed = (modeSel == adc_cfg_pkg::MODE_COUNT)
                                  || (modeSel == adc_cfg_pkg::MODE_STATIC && writeUnlockReg);
   assign waveCtrl.softReset = softResetHit;
   assign waveCtrl.wrEn = regWrite;
   assign waveCtrl.wrAddr = regAddr;
   assign waveCtrl.wrData = regWdata;
   assign waveResult = '{currentResult, firstVoltageResult, secondVoltageResult};

   // Current, first voltage and second voltage channels at consecutive groups.
   for (genvar ch = 0; ch < adc_cfg_pkg::NUM_CHANNELS; ch++)
   begin : gen_wave
      waveform_channel #(
         .BASE_ADDR(adc_cfg_pkg::WAVE_BASE_ADDR + adc_cfg_pkg::WAVE_STRIDE * 8'(ch))
      ) u_chan (
         .ref_clk(ref_clk),
         .rst_b(rst_b),
         .ctrl(waveCtrl.channel),
         .result(waveResult[ch]),
         .waveValue(waveValue[ch])
      );
   end

   // Clock for other devices is ref_clk halved; the pin is registered so it is glitch free.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         clkDivReg <= 1'b0;
         pinReg <= 1'b1;
      end
      else
      begin
         clkDivReg <= ~clkDivReg;
         if (generalCfgReg[adc_cfg_pkg::CLOCK_OUTPUT_ENABLE_BIT])
            pinReg <= clkDivReg; // [RULE8]
         else
            pinReg <= ~sampleReadyPulse; // Active-low sample ready. [RULE8]
      end
   end

   // Path decode: compensation, lowpass and output rate.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lowpassReg <= 1'b0;
         compReg <= 1'b0;
         rateReg <= adc_cfg_pkg::RATE_32K;
      end
      else
      begin
         lowpassReg <= (filterCfgReg[2:0] != 3'h0); // [RULE11]
         compReg <= (filterCfgReg[2:0] == 3'h2) || (filterCfgReg[2:0] == 3'h4); // [RULE14]
         case (filterCfgReg[2:0])
            3'h3, 3'h4: rateReg <= adc_cfg_pkg::RATE_8K; // [RULE14]
            3'h5: rateReg <= adc_cfg_pkg::RATE_4K;
            3'h6, 3'h7: rateReg <= adc_cfg_pkg::RATE_2K;
            default: rateReg <= adc_cfg_pkg::RATE_32K; // [RULE11]
         endcase
      end
   end

   // Read mux; unmapped and write-only addresses return zero.
   always_comb
   begin
      rdataNext = 8'h00; // Reset command register reads zero. [RULE15]
      if (regAddr == adc_cfg_pkg::GENERAL_CFG_ADDR)
         rdataNext = generalCfgReg;
      else if (regAddr == adc_cfg_pkg::FILTER_CFG_ADDR)
         rdataNext = filterCfgReg;
      else if (regAddr == adc_cfg_pkg::ISO_ACCESS_ADDR)
         rdataNext = isoAccessReg;
      else if (regAddr == adc_cfg_pkg::SHORT_ADDR)
         rdataNext = shortReg;
      else if (regAddr >= adc_cfg_pkg::WAVE_BASE_ADDR && regAddr <= adc_cfg_pkg::WAVE_LAST_ADDR)
      begin
         for (int i = 0; i < adc_cfg_pkg::NUM_CHANNELS; i++)
         begin
            if (regAddr == adc_cfg_pkg::WAVE_BASE_ADDR + adc_cfg_pkg::WAVE_STRIDE * 8'(i))
               rdataNext = waveValue[i][23:16];
            else if (regAddr == adc_cfg_pkg::WAVE_BASE_ADDR + adc_cfg_pkg::WAVE_STRIDE * 8'(i)
                     + 8'h01)
               rdataNext = waveValue[i][15:8];
            else if (regAddr == adc_cfg_pkg::WAVE_BASE_ADDR + adc_cfg_pkg::WAVE_STRIDE * 8'(i)
                     + 8'h02)
               rdataNext = waveValue[i][7:0];
         end
      end
   end

   // Read data is captured one cycle after the strobe.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rdataReg <= 8'h00;
         rdValidReg <= 1'b0;
      end
      else
      begin
         rdValidReg <= regRead;
         if (regRead)
            rdataReg <= rdataNext;
      end
   end

   // Outputs straight from register bits.
   assign regRdata = rdataReg;
   assign regRdValid = rdValidReg;
   assign waveformDebugSelect = modeSel;
   assign crcCheckEnable = generalCfgReg[adc_cfg_pkg::CRC_EN_BIT]; // [RULE7]
   assign clockOutputEnable = generalCfgReg[adc_cfg_pkg::CLOCK_OUTPUT_ENABLE_BIT];
   assign clockOutputPin = pinReg;
   assign secondVoltageInvert = filterCfgReg[adc_cfg_pkg::V2_INV_BIT]; // [RULE9]
   assign firstVoltageInvert = filterCfgReg[adc_cfg_pkg::V1_INV_BIT]; // [RULE9]
   assign currentInvert = filterCfgReg[adc_cfg_pkg::I_INV_BIT]; // [RULE9]
   assign lowpassBandwidthSelect = filterCfgReg[adc_cfg_pkg::LOWPASS_BANDWIDTH_SELECT_BIT]; // 1: 2.7k. [RULE10]
   assign processingPathSelect = filterCfgReg[2:0];
   assign lowpassEnable = lowpassReg;
   assign compensationEnable = compReg;
   assign sampleRateSelect = rateReg;
   assign isolatedWriteEnable = isoAccessReg[adc_cfg_pkg::ISO_WR_BIT];
   assign currentInputShort = shortReg[0];

   property p_soft_reset;
      @(posedge ref_clk) disable iff (!rst_b)
      softResetHit |=> (generalCfgReg == adc_cfg_pkg::GENERAL_CFG_RESET && filterCfgReg == 8'h00
                        && shortReg == 8'h00 && isoAccessReg == 8'h00);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("Soft reset incomplete."); // [RULE1]

   property p_crc_default;
      @(posedge ref_clk) disable iff (!rst_b)
      softResetHit |=> crcCheckEnable;
   endproperty
   a_crc_default: assert property (p_crc_default) else $error("CRC off after reset."); // [RULE7]

   property p_ready_pin;
      @(posedge ref_clk) disable iff (!rst_b)
      !clockOutputEnable ##1 !clockOutputEnable |-> (clockOutputPin == !$past(sampleReadyPulse));
   endproperty
   a_ready_pin: assert property (p_ready_pin) else $error("Pin not the ready pulse."); // [RULE8]

   property p_short_lock;
      @(posedge ref_clk) disable iff (!rst_b)
      (regWrite && regAddr == adc_cfg_pkg::SHORT_ADDR && !isolatedWriteEnable && !softResetHit)
      |=> $stable(shortReg);
   endproperty
   a_short_lock: assert property (p_short_lock) else $error("Short written locked."); // [RULE13]

   property p_reset_cmd_zero;
      @(posedge ref_clk) disable iff (!rst_b)
      (regRead && regAddr == adc_cfg_pkg::SOFT_RESET_ADDR) |=> (regRdValid && regRdata == 8'h00);
   endproperty
   a_reset_cmd_zero: assert property (p_reset_cmd_zero) else $error("Bad read."); // [RULE15]

   property p_sinc_only;
      @(posedge ref_clk) disable iff (!rst_b)
      (processingPathSelect == 3'h0) ##1 (processingPathSelect == 3'h0)
      |-> (!lowpassEnable && sampleRateSelect == adc_cfg_pkg::RATE_32K);
   endproperty
   a_sinc_only: assert property (p_sinc_only) else $error("Sinc path has lowpass."); // [RULE11]

   property p_reserved_zero;
      @(posedge ref_clk) disable iff (!rst_b)
      (generalCfgReg[7:4] == 4'h0) && !filterCfgReg[7] && (shortReg[7:1] == 7'h00);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit set."); // [RULE16]

   property p_rate_8k;
      @(posedge ref_clk) disable iff (!rst_b)
      (processingPathSelect == 3'h4) ##1 (processingPathSelect == 3'h4)
      |-> (compensationEnable && lowpassEnable && sampleRateSelect == adc_cfg_pkg::RATE_8K);
   endproperty
   a_rate_8k: assert property (p_rate_8k) else $error("Path 100 decoded wrong."); // [RULE14]
endmodule : adc_config_register_bank
`default_nettype wire

/* adc_host_model.sv */
// Host-side model that issues register strobes as the SPI frame logic would.
`timescale 1ns/100ps
`default_nettype none
module adc_host_model (
   input wire logic ref_clk,
   output logic regWrite,
   output logic regRead,
   output logic [7:0] regAddr,
   output logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   input wire logic regRdValid
);
   // Strobes idle low from time zero, so nothing is taken during reset.
   initial
   begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'h00;
      regWdata = 8'h00;
   end

   // One byte write; afterwards address and data show the inverse, not a stale copy.
   task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge ref_clk);
      regWrite = 1'b1;
      regAddr = addr;
      regWdata = data;
      @(negedge ref_clk);
      regWrite = 1'b0;
      regAddr = ~addr;
      regWdata = ~data;
   endtask : writeReg

   // One byte read with a bounded wait for the answer strobe.
   task automatic readReg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      ok = 1'b0;
      data = 8'h00;
      @(negedge ref_clk);
      regRead = 1'b1;
      regAddr = addr;
      @(negedge ref_clk);
      regRead = 1'b0;
      regAddr = ~addr;
      for (int i = 0; i < 4 && !ok; i++)
      begin
         if (regRdValid === 1'b1)
         begin
            data = regRdata;
            ok = 1'b1;
         end
         else
            @(negedge ref_clk);
      end
   endtask : readReg
endmodule : adc_host_model
`default_nettype wire

/* adc_config_register_bank_test.sv */
// Self-checking testbench for the ADC configuration register bank.
`timescale 1ns/100ps
`default_nettype none
module adc_config_register_bank_test;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic regWrite, regRead, regRdValid;
   logic sampleReadyPulse = 1'b0;
   logic [7:0] regAddr, regWdata, regRdata;
   logic [23:0] currentResult = 24'h000000;
   logic [23:0] firstVoltageResult = 24'h000000;
   logic [23:0] secondVoltageResult = 24'h000000;
   logic [1:0] waveformDebugSelect, sampleRateSelect;
   logic crcCheckEnable, clockOutputEnable, clockOutputPin, secondVoltageInvert;
   logic firstVoltageInvert, currentInvert, lowpassBandwidthSelect, lowpassEnable;
   logic compensationEnable, isolatedWriteEnable, currentInputShort, pinA;
   logic [2:0] processingPathSelect;
   // Expected {path, lowpass, compensation, rate} for each path code.
   logic [7:0] pathExp [8] = '{8'h00, 8'h18, 8'h2C, 8'h39, 8'h4D, 8'h5A, 8'h6B, 8'h7B};
   int errors = 0;
   int comparisons = 0;

   // A 25 ns clock.
   always #12.5 ref_clk = ~ref_clk;

   adc_config_register_bank uut (.ref_clk, .rst_b, .regWrite, .regRead, .regAddr, .regWdata,
      .regRdata, .regRdValid, .sampleReadyPulse, .currentResult, .firstVoltageResult,
      .secondVoltageResult, .waveformDebugSelect, .crcCheckEnable, .clockOutputEnable,
      .clockOutputPin, .secondVoltageInvert, .firstVoltageInvert, .currentInvert,
      .lowpassBandwidthSelect, .processingPathSelect, .lowpassEnable, .compensationEnable,
      .sampleRateSelect, .isolatedWriteEnable, .currentInputShort);

   adc_host_model host (.ref_clk, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
      .regRdValid);

   task automatic stop_test();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test

   // Compare a register byte read back over the register port.
   task automatic checkReg(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: register %0h expected %0h", $time, got, exp);
      end
   endtask : checkReg

   // Compare a value seen directly on the output ports.
   task automatic checkPort(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: port %0h expected %0h", $time, got, exp);
      end
   endtask : checkPort

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      host.writeReg(addr, data);
   endtask : wr

   // A lost answer ends the run at once rather than cascading into noise.
   task automatic rdExpect(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] data;
      logic ok;
      host.readReg(addr, data, ok);
      if (!ok)
      begin
         errors++;
         stop_test();
      end
      else
         checkReg(data, exp);
   endtask : rdExpect

   // Bytes are read high first; they are not an atomic snapshot.
   task automatic readWave(input logic [7:0] base, input logic [23:0] exp);
      rdExpect(base, exp[23:16]);
      rdExpect(base + 8'h01, exp[15:8]);
      rdExpect(base + 8'h02, exp[7:0]);
   endtask : readWave

   task automatic pulse();
      @(negedge ref_clk);
      sampleReadyPulse = 1'b1;
      @(negedge ref_clk);
      sampleReadyPulse = 1'b0;
   endtask : pulse

   task automatic testDefaults();
      rdExpect(8'h02, 8'h02);
      rdExpect(8'h03, 8'h00);
      rdExpect(8'h01, 8'h00);
      rdExpect(8'hCC, 8'h00);
      rdExpect(8'h40, 8'h00);
      checkPort(crcCheckEnable, 8'h01);
      $display("test defaults done");
   endtask : testDefaults

   task automatic testGeneral();
      wr(8'h02, 8'hF1);
      rdExpect(8'h02, 8'h01);
      checkPort(crcCheckEnable, 8'h00);
      checkPort(clockOutputEnable, 8'h01);
      pinA = clockOutputPin;
      @(negedge ref_clk);
      checkPort({7'h00, clockOutputPin}, {7'h00, ~pinA});
      wr(8'h02, 8'h02);
      checkPort(crcCheckEnable, 8'h01);
      pulse();
      checkPort(clockOutputPin, 8'h00);
      @(negedge ref_clk);
      checkPort(clockOutputPin, 8'h01);
      $display("test general config done");
   endtask : testGeneral

   task automatic testFilter();
      wr(8'h03, 8'hFF);
      rdExpect(8'h03, 8'h7F);
      checkPort({secondVoltageInvert, firstVoltageInvert, currentInvert}, 8'h07);
      checkPort(lowpassBandwidthSelect, 8'h01);
      wr(8'h03, 8'h40);
      checkPort({secondVoltageInvert, firstVoltageInvert, currentInvert}, 8'h04);
      checkPort(lowpassBandwidthSelect, 8'h00);
      for (int code = 0; code < 8; code++)
      begin
         wr(8'h03, {5'h00, code[2:0]});
         @(negedge ref_clk);
         checkPort({processingPathSelect, lowpassEnable, compensationEnable,
            sampleRateSelect}, pathExp[code]);
      end
      $display("test filter config done");
   endtask : testFilter

   task automatic testShort();
      wr(8'hCC, 8'h01);
      rdExpect(8'hCC, 8'h00);
      wr(8'h05, 8'hFF);
      rdExpect(8'h05, 8'h01);
      checkPort(isolatedWriteEnable, 8'h01);
      wr(8'hCC, 8'hFF);
      rdExpect(8'hCC, 8'h01);
      checkPort(currentInputShort, 8'h01);
      wr(8'h05, 8'h00);
      wr(8'hCC, 8'h00);
      checkPort(currentInputShort, 8'h01);
      $display("test input short done");
   endtask : testShort

   task automatic testWave();
      currentResult = 24'h123456;
      secondVoltageResult = 24'h0F1E2D;
      pulse();
      readWave(8'h26, 24'h123456);
      readWave(8'h2C, 24'h0F1E2D);
      wr(8'h26, 8'h77);
      readWave(8'h26, 24'h123456);
      wr(8'h02, 8'h0E);
      checkPort(waveformDebugSelect, 8'h03);
      currentResult = 24'h654321;
      pulse();
      readWave(8'h26, 24'h654321);
      // Count mode goes first so that static mode may later be written.
      wr(8'h02, 8'h0A);
      wr(8'h26, 8'h00);
      wr(8'h27, 8'h00);
      wr(8'h28, 8'hFF);
      pulse();
      readWave(8'h26, 24'h000100);
      pulse();
      readWave(8'h26, 24'h000101);
      wr(8'h02, 8'h06);
      currentResult = 24'hAAAAAA;
      pulse();
      readWave(8'h26, 24'h000101);
      wr(8'h2B, 8'h55);
      rdExpect(8'h2B, 8'h55);
      $display("test waveform modes done");
   endtask : testWave

   task automatic testSoftReset();
      wr(8'h03, 8'h48);
      wr(8'h01, 8'h55);
      rdExpect(8'h03, 8'h48);
      wr(8'h05, 8'h01);
      wr(8'h01, 8'hD6);
      rdExpect(8'h03, 8'h00);
      rdExpect(8'h02, 8'h02);
      rdExpect(8'h05, 8'h00);
      readWave(8'h26, 24'h000000);
      checkPort(crcCheckEnable, 8'h01);
      rdExpect(8'hCC, 8'h00);
      // Static straight from normal must not unlock waveform writes.
      wr(8'h02, 8'h06);
      wr(8'h26, 8'h33);
      rdExpect(8'h26, 8'h00);
      $display("test soft reset done");
   endtask : testSoftReset

   // Main sequence: reset for 16 cycles, released off the sampling edge.
   initial
   begin
      repeat (16) @(negedge ref_clk);
      rst_b = 1'b1;
      testDefaults();
      testGeneral();
      testFilter();
      testShort();
      testWave();
      testSoftReset();
      stop_test();
   end

   // Watchdog so that a stuck design cannot hang the run.
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      $display("Error at %0t: run limit %0h reached %0h", $time, 20000, 20000);
      stop_test();
   end
endmodule : adc_config_register_bank_test
`default_nettype wire
